/* File: rtl/umc_defs.vh */
`ifndef UMC_DEFS_VH
`define UMC_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define UMC_A_IEN     3'h0
`define UMC_A_ISID    3'h1
`define UMC_A_EFR     3'h2
`define UMC_A_MCTL    3'h3
`define UMC_A_MSTAT   3'h4
`define UMC_A_FTHR    3'h5
`define UMC_A_XOFF2   3'h6
`define UMC_A_TLVL    3'h7
// ****************************************
// field positions
// ****************************************
`define UMC_MC_LOOP   4
`define UMC_MC_TACC   6
`define UMC_MC_DIV4   7
`define UMC_EF_WEN    4
`define UMC_EF_SPEC   5
`define UMC_EF_ARTS   6
`define UMC_EF_ACTS   7
`define UMC_FC_EN     0
`define UMC_FC_RXCLR  1
`define UMC_FC_TXCLR  2
// ****************************************
// reset values
// ****************************************
`define UMC_RST_BYTE  8'h00
`define UMC_RST_LINES 4'h0
// ****************************************
// interrupt source codes, bits 5..0
// ****************************************
`define UMC_ID_LINE   6'h06
`define UMC_ID_TOUT   6'h0c
`define UMC_ID_RHR    6'h04
`define UMC_ID_THR    6'h02
`define UMC_ID_MODEM  6'h00
`define UMC_ID_XOFF   6'h10
`define UMC_ID_FLOW   6'h20
// ****************************************
// timing and scaling
// ****************************************
`define UMC_PRE_DIV4  2'h3
`define UMC_THR_STEP  2
`endif

/* File: rtl/umc_ctrl.v */
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "umc_defs.vh"
module umc_ctrl
(
  input  wire       mclk_in,
  input  wire       rstn_in,
  input  wire [2:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire       cts_n_in,
  input  wire       dsr_n_in,
  input  wire       ri_n_in,
  input  wire       cd_n_in,
  output reg        dtr_n_out,
  output reg        rts_n_out,
  input  wire       tx_ser_in,
  input  wire       rx_pin_in,
  output reg        tx_pin_out,
  output reg        rx_ser_out,
  input  wire [6:0] rx_fill_in,
  input  wire [7:0] rx_char_in,
  input  wire       rx_char_vld_in,
  input  wire       line_err_in,
  input  wire       rx_tout_in,
  input  wire       rx_data_in,
  input  wire       thr_empty_in,
  input  wire       xoff_rcvd_in,
  output reg        int_out,
  output reg        int_oe_out,
  output reg        tx_halt_out,
  output reg        baud_tick_out,
  output reg        sleep_en_out,
  output reg        xon_any_out,
  output reg        frr_en_out,
  output reg        fifo_en_out,
  output reg        rx_clr_out,
  output reg        tx_clr_out,
  output reg  [3:0] sw_flow_out,
  output reg  [7:0] trig_lvl_out
);

// ****************************************
// decode helpers
// ****************************************
// field value scaled to a byte count
function [6:0] thr4;
  input [3:0] f;
  begin
    thr4 = {1'b0, f, 2'b00};
  end
endfunction

// strobe hit on one offset, for writes and reads
function hit;
  input       s;
  input [2:0] a;
  input [2:0] o;
  begin
    hit = s && (a == o);
  end
endfunction

// ****************************************
// registers
// ****************************************
reg  [7:0] ien_r;
reg  [7:0] mctl_r;
reg  [7:0] efr_r;
reg  [7:0] fctl_r;
reg  [7:0] fthr_r;
reg  [7:0] xoff2_r;
reg  [3:0] line_r;
reg  [3:0] prev_r;
reg  [3:0] dlt_r;
reg        spec_r;
reg        flow_r;
reg        rts_hold_r;
reg        rts_prev_r;
reg        cts_prev_r;
reg  [1:0] pre_r;
wire       id_lvl5;
wire       id_lvl6;
wire       wen = efr_r[`UMC_EF_WEN];
wire       loop = mctl_r[`UMC_MC_LOOP];
wire       tacc = wen && mctl_r[`UMC_MC_TACC];
wire       w_ien = hit(wr_in, addr_in, `UMC_A_IEN);
wire       w_fc = hit(wr_in, addr_in, `UMC_A_ISID);
wire       w_mc = hit(wr_in, addr_in, `UMC_A_MCTL);
wire       r_ms = hit(rd_in, addr_in, `UMC_A_MSTAT);
wire       r_id = hit(rd_in, addr_in, `UMC_A_ISID);

// ****************************************
// software registers
// ****************************************
// upper enable bits only move with the write gate open
always @(posedge mclk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    ien_r   <= `UMC_RST_BYTE;
    mctl_r  <= `UMC_RST_BYTE;
    efr_r   <= `UMC_RST_BYTE;
    fctl_r  <= `UMC_RST_BYTE;
    fthr_r  <= `UMC_RST_BYTE;
    xoff2_r <= `UMC_RST_BYTE;
    trig_lvl_out <= `UMC_RST_BYTE;
  end
  else
  begin
    if (w_ien)
      ien_r <= {wen ? wdata_in[7:4] : ien_r[7:4], wdata_in[3:0]};
    if (w_mc)
      mctl_r <= {wen ? wdata_in[7:5] : mctl_r[7:5], wdata_in[4:0]};
    if (w_fc)
      fctl_r <= {wdata_in[7:6], wen ? wdata_in[5:4] : fctl_r[5:4], wdata_in[3:0]};
    if (hit(wr_in, addr_in, `UMC_A_EFR))
      efr_r <= wdata_in;
    if (hit(wr_in, addr_in, `UMC_A_XOFF2))
      xoff2_r <= wdata_in;
    // clearing control bit 6 only closes access again
    if (tacc && hit(wr_in, addr_in, `UMC_A_FTHR))
      fthr_r <= wdata_in;
    if (tacc && hit(wr_in, addr_in, `UMC_A_TLVL))
      trig_lvl_out <= wdata_in;
  end
end

// ****************************************
// modem line sampling
// ****************************************
// order cd, ri, dsr, cts matches status bits 7..4
wire [3:0] pin_hi = {~cd_n_in, ~ri_n_in, ~dsr_n_in, ~cts_n_in};
wire [3:0] lb_hi = {mctl_r[3], mctl_r[2], mctl_r[0], mctl_r[1]};

always @(posedge mclk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    line_r <= `UMC_RST_LINES;
    prev_r <= `UMC_RST_LINES;
  end
  else
  begin
    line_r <= loop ? lb_hi : pin_hi;
    prev_r <= line_r;
  end
end

// ****************************************
// change flags
// ****************************************
// status bit order is cts, dsr, ri, cd; line_r order cd, ri, dsr, cts
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1)
  begin : g_dlt
    // ri counts only the pin going high, or control bit 2 rising in loopback
    wire chg = (line_r[gi] != prev_r[gi]) && ((gi != 2) || (line_r[gi] == loop));
    always @(posedge mclk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        dlt_r[gi] <= 1'b0;
      else if (chg)
        dlt_r[gi] <= 1'b1; // set wins over read clear
      else if (r_ms)
        dlt_r[gi] <= 1'b0;
    end
  end
endgenerate

// line index -> status bit: cts0 dsr1 ri2 cd3
wire [7:0] mstat = {line_r[3], line_r[2], line_r[1], line_r[0],
                    dlt_r[3], dlt_r[2], dlt_r[1], dlt_r[0]};

// ****************************************
// flow control
// ****************************************
// halt above restore assumed; software must program it so
always @(posedge mclk_in or negedge rstn_in)
begin
  if (!rstn_in)
    rts_hold_r <= 1'b0;
  else if (rx_fill_in >= thr4(fthr_r[3:0]))
    rts_hold_r <= 1'b1;
  else if (rx_fill_in <= thr4(fthr_r[7:4]))
    rts_hold_r <= 1'b0;
end

// ****************************************
// event flags for levels 5 and 6
// ****************************************
wire spec_hit = efr_r[`UMC_EF_SPEC] && rx_char_vld_in && (rx_char_in == xoff2_r);
wire rts_rise = ien_r[6] && rts_n_out && !rts_prev_r;
wire cts_rise = ien_r[7] && cts_n_in && !cts_prev_r;

always @(posedge mclk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    spec_r     <= 1'b0;
    flow_r     <= 1'b0;
    rts_prev_r <= 1'b1;
    cts_prev_r <= 1'b1;
  end
  else
  begin
    rts_prev_r <= rts_n_out;
    cts_prev_r <= cts_n_in;
    // reading the id clears a flag only once it is on show
    if (spec_hit || xoff_rcvd_in)
      spec_r <= 1'b1;
    else if (r_id && id_lvl5)
      spec_r <= 1'b0;
    if (rts_rise || cts_rise)
      flow_r <= 1'b1;
    else if (r_id && id_lvl6)
      flow_r <= 1'b0;
  end
end

// ****************************************
// interrupt priority
// ****************************************
wire s_line = ien_r[2] && line_err_in;
wire s_tout = ien_r[0] && rx_tout_in;
wire s_rhr = ien_r[0] && rx_data_in;
wire s_thr = ien_r[1] && thr_empty_in;
wire s_mdm = ien_r[3] && (|dlt_r);
wire s_xoff = ien_r[5] && spec_r;
wire s_flow = flow_r;
wire any = s_line | s_tout | s_rhr | s_thr | s_mdm | s_xoff | s_flow;
assign id_lvl5 = s_xoff && !(s_line | s_tout | s_rhr | s_thr | s_mdm);
assign id_lvl6 = s_flow && !(s_line | s_tout | s_rhr | s_thr | s_mdm | s_xoff);
reg  [5:0] id_code;

always @*
begin
  if (s_line)
    id_code = `UMC_ID_LINE;
  else if (s_tout)
    id_code = `UMC_ID_TOUT;
  else if (s_rhr)
    id_code = `UMC_ID_RHR;
  else if (s_thr)
    id_code = `UMC_ID_THR;
  else if (s_mdm)
    id_code = `UMC_ID_MODEM;
  else if (s_xoff)
    id_code = `UMC_ID_XOFF;
  else if (s_flow)
    id_code = `UMC_ID_FLOW;
  else
    id_code = 6'h00;
end

wire fen = fctl_r[`UMC_FC_EN];
wire [7:0] isid = {fen, fen, id_code[5:1], id_code[0] | !any};

// ****************************************
// read port
// ****************************************
// data stands one cycle, zero otherwise
always @(posedge mclk_in or negedge rstn_in)
begin
  if (!rstn_in)
    rdata_out <= `UMC_RST_BYTE;
  else if (!rd_in)
    rdata_out <= `UMC_RST_BYTE;
  else if (addr_in == `UMC_A_IEN)
    rdata_out <= ien_r;
  else if (addr_in == `UMC_A_ISID)
    rdata_out <= isid;
  else if (addr_in == `UMC_A_EFR)
    rdata_out <= efr_r;
  else if (addr_in == `UMC_A_MCTL)
    rdata_out <= mctl_r;
  else if (addr_in == `UMC_A_MSTAT)
    rdata_out <= mstat;
  else if (addr_in == `UMC_A_FTHR)
    rdata_out <= fthr_r;
  else if (addr_in == `UMC_A_XOFF2)
    rdata_out <= xoff2_r;
  else
    rdata_out <= trig_lvl_out;
end

// ****************************************
// prescaler
// ****************************************
// tick every cycle, or every fourth with divide by four
always @(posedge mclk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    pre_r         <= 2'h0;
    baud_tick_out <= 1'b0;
  end
  else
  begin
    pre_r         <= mctl_r[`UMC_MC_DIV4] ? pre_r + 2'h1 : 2'h0;
    baud_tick_out <= !mctl_r[`UMC_MC_DIV4] || (pre_r == `UMC_PRE_DIV4);
  end
end

// ****************************************
// output pins and controls
// ****************************************
// loopback parks modem outputs inactive and idles tx high
always @(posedge mclk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    dtr_n_out   <= 1'b1;
    rts_n_out   <= 1'b1;
    tx_pin_out  <= 1'b1;
    rx_ser_out  <= 1'b1;
    int_out     <= 1'b0;
    int_oe_out  <= 1'b0;
    tx_halt_out <= 1'b0;
    sleep_en_out <= 1'b0;
    xon_any_out <= 1'b0;
    frr_en_out  <= 1'b0;
    fifo_en_out <= 1'b0;
    rx_clr_out  <= 1'b0;
    tx_clr_out  <= 1'b0;
    sw_flow_out <= 4'h0;
  end
  else
  begin
    dtr_n_out   <= loop || !mctl_r[0];
    if (loop)
      rts_n_out <= 1'b1;
    else if (efr_r[`UMC_EF_ARTS])
      rts_n_out <= rts_hold_r;
    else
      rts_n_out <= !mctl_r[1];
    tx_pin_out  <= loop || tx_ser_in;
    rx_ser_out  <= loop ? tx_ser_in : rx_pin_in;
    int_out     <= any;
    int_oe_out  <= mctl_r[3];
    tx_halt_out <= efr_r[`UMC_EF_ACTS] && !line_r[0];
    sleep_en_out <= ien_r[4];
    xon_any_out <= mctl_r[5];
    frr_en_out  <= mctl_r[2] && !loop;
    fifo_en_out <= fen;
    rx_clr_out  <= w_fc && wdata_in[`UMC_FC_RXCLR];
    tx_clr_out  <= w_fc && wdata_in[`UMC_FC_TXCLR];
    sw_flow_out <= efr_r[3:0];
  end
end

endmodule

/* File: verification/umc_modem.sv */
`timescale 1ns/1ns
// ******
// far-side modem on the status lines
// ******
module umc_modem
(
  input  wire       clk_in,
  input  wire [3:0] want_in,
  output reg        cts_n_out,
  output reg        dsr_n_out,
  output reg        ri_n_out,
  output reg        cd_n_out
);
  // lines idle inactive high, as an unplugged modem would leave them
  initial {cd_n_out, ri_n_out, dsr_n_out, cts_n_out} = 4'hf;
  // a high cts pauses the near transmitter
  always @(posedge clk_in)
    {cd_n_out, ri_n_out, dsr_n_out, cts_n_out} <= want_in;
endmodule

/* File: verification/umc_ctrl_checker.sv */
`timescale 1ns/1ns
module umc_ctrl_checker
(
  input wire       mclk_in,
  input wire       rstn_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       cts_n_in,
  input wire       dtr_n_out,
  input wire       rts_n_out,
  input wire       int_out,
  input wire       int_oe_out,
  input wire       tx_halt_out,
  input wire       baud_tick_out
);
  reg [7:0] ef_r;
  reg       fen_r;
  reg       div4_r;
  reg       loop_r;
  reg [2:0] stab_r;
  wire      mc_w = wr_in && addr_in == 3'h3;
  // shadows of mode bits; stab counts quiet cycles after a control write
  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ef_r   <= 8'h00;
      fen_r  <= 1'h0;
      div4_r <= 1'h0;
      loop_r <= 1'h0;
      stab_r <= 3'h0;
    end
    else
    begin
      if (wr_in && addr_in == 3'h2)
        ef_r <= wdata_in;
      if (wr_in && addr_in == 3'h1)
        fen_r <= wdata_in[0];
      if (mc_w && ef_r[4])
        div4_r <= wdata_in[7];
      if (mc_w)
        loop_r <= wdata_in[4];
      stab_r <= mc_w ? 3'h0 : stab_r + {2'h0, stab_r != 3'h7};
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // ******
  // properties
  // ******
  sequence mc_norm;
    mc_w && !wdata_in[4];
  endsequence
  sequence mc_loop;
    mc_w && wdata_in[4];
  endsequence
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  a_dtr_follows: assert property (mc_norm |-> ##2 dtr_n_out == !$past(wdata_in[0], 2))
    else $error("dtr wrong");
  a_rts_follows: assert property (mc_norm ##0 !ef_r[6] |-> ##2 rts_n_out == !$past(wdata_in[1], 2))
    else $error("rts wrong");
  a_loop_quiet: assert property (mc_loop |-> ##2 dtr_n_out && rts_n_out)
    else $error("pins active in loopback");
  a_int_drive: assert property (mc_w |-> ##2 int_oe_out == $past(wdata_in[3], 2))
    else $error("int drive wrong");
  a_div1_tick: assert property (stab_r == 3'h7 && !div4_r |-> baud_tick_out)
    else $error("tick missing");
  a_div4_gap: assert property (stab_r == 3'h7 && div4_r && baud_tick_out
    |=> (!baud_tick_out || stab_r < 3'h3) [*3])
    else $error("tick too soon");
  a_cts_halt: assert property ((ef_r[7] && !loop_r && cts_n_in) [*3] |-> tx_halt_out)
    else $error("no halt");
  a_id_pending: assert property ($past(rd_in && addr_in == 3'h1) && $stable(int_out)
    |-> rdata_out[0] == !int_out)
    else $error("pending bit wrong");
  a_fifo_mirror: assert property ($past(rd_in && addr_in == 3'h1)
    |-> rdata_out[7:6] == {2{$past(fen_r)}})
    else $error("mirror wrong");
endmodule
bind umc_ctrl umc_ctrl_checker umc_ctrl_checker_inst (.*);

/* File: verification/tb_uart_modem_irq_flow_control.sv */
`timescale 1ns/1ns
module tb_uart_modem_irq_flow_control;
  logic        mclk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [2:0]  addr_in = 3'h0;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [3:0]  want = 4'hf;
  logic        tx_ser_in = 1'b1;
  logic        rx_pin_in = 1'b1;
  logic [6:0]  rx_fill_in = 7'h00;
  logic [7:0]  rx_char_in = 8'h13;
  logic        rx_char_vld_in = 1'b0;
  logic        line_err_in = 1'b0;
  logic        rx_tout_in = 1'b0;
  logic        rx_data_in = 1'b0;
  logic        thr_empty_in = 1'b0;
  logic        xoff_rcvd_in = 1'b0;
  wire  [7:0]  rdata_out;
  wire         cts_n_in, dsr_n_in, ri_n_in, cd_n_in;
  wire         dtr_n_out, rts_n_out, tx_pin_out, rx_ser_out, int_out, tx_halt_out;
  logic [7:0]  exp_q[$];
  logic [7:0]  msk_q[$];
  logic [7:0]  ic [5] = '{8'hc6, 8'hcc, 8'hc4, 8'hc2, 8'hc1};
  logic [7:0]  fl [5] = '{8'h00, 8'h0f, 8'h10, 8'h0c, 8'h08};
  logic [31:0] seed = 32'h0000_0009;
  logic [3:0]  prv;
  logic [3:0]  dl;
  logic        rd_p = 1'b0;
  int          n_mismatch = 0;
  int          tests_run = 0;
  umc_ctrl umc_ctrl_inst (.*, .int_oe_out(), .baud_tick_out(), .sleep_en_out(), .xon_any_out(),
    .frr_en_out(), .fifo_en_out(), .rx_clr_out(), .tx_clr_out(), .sw_flow_out(), .trig_lvl_out());
  umc_modem umc_modem_inst (.clk_in(mclk_in), .want_in(want), .cts_n_out(cts_n_in),
    .dsr_n_out(dsr_n_in), .ri_n_out(ri_n_in), .cd_n_out(cd_n_in));
  // ******
  // helpers
  // ******
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  // a zero mask bit marks a don't-care bit of the answer
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask
  initial
    forever #4 mclk_in = ~mclk_in;
  // read data stand one cycle after the strobe, so look one half-cycle later
  always @(negedge mclk_in)
  begin
    if (rd_p)
      chk("rdata", exp_q.pop_front(), rdata_out & msk_q.pop_front());
    rd_p = rd_in;
  end
  // the whole run needs about 240 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd(3'h3, 8'h00, 8'hff);
    rd(3'h1, 8'h01, 8'hff);
    wr(3'h0, 8'hff);
    rd(3'h0, 8'h0f, 8'hff);
    wr(3'h3, 8'he0);
    rd(3'h3, 8'h00, 8'hff);
    wr(3'h2, 8'h10);
    wr(3'h0, 8'hf0);
    rd(3'h0, 8'hf0, 8'hff);
    wr(3'h3, 8'he0);
    rd(3'h3, 8'he0, 8'hff);
    wr(3'h5, 8'h24);
    rd(3'h5, 8'h24, 8'hff);
    repeat (16) @(posedge mclk_in);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h08);
    rd(3'h4, 8'h00, 8'h00);
    // random line changes; ri flags only its trailing edge
    repeat (8)
    begin
      seed = xs(seed);
      prv = want;
      want <= seed[3:0];
      dl = prv ^ seed[3:0];
      dl[2] = !prv[2] && seed[2];
      repeat (4) @(posedge mclk_in);
      rd(3'h1, {7'h00, dl == 4'h0}, 8'hff);
      rd(3'h4, {~seed[3:0], dl}, 8'hff);
    end
    wr(3'h0, 8'h07);
    wr(3'h3, 8'h1b);
    tx_ser_in <= 1'b0;
    // let the loopback deltas settle so the clearing read is not beaten by a set
    repeat (3) @(posedge mclk_in);
    rd(3'h4, 8'h00, 8'h00);
    rd(3'h4, 8'hb0, 8'hff);
    @(negedge mclk_in);
    chk("loop", 8'h02, {6'h00, tx_pin_out, rx_ser_out});
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h01);
    // sources from highest priority down; modem source masked
    for (int i = 0; i < 5; i++)
    begin
      {line_err_in, rx_tout_in, rx_data_in, thr_empty_in} <= 4'hf >> i;
      repeat (3) @(posedge mclk_in);
      rd(3'h1, ic[i], 8'hff);
      @(negedge mclk_in);
      chk("int", {7'h00, i < 4}, {7'h00, int_out});
    end
    {line_err_in, rx_tout_in, rx_data_in, thr_empty_in} <= 4'hf;
    wr(3'h0, 8'h00);
    rd(3'h1, 8'hc1, 8'hff);
    {line_err_in, rx_tout_in, rx_data_in, thr_empty_in} <= 4'h0;
    wr(3'h0, 8'h60);
    wr(3'h6, 8'h13);
    wr(3'h2, 8'h30);
    for (int j = 0; j < 2; j++)
    begin
      xoff_rcvd_in <= j == 0;
      rx_char_vld_in <= j == 1;
      @(posedge mclk_in);
      xoff_rcvd_in <= 1'b0;
      rx_char_vld_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rd(3'h1, 8'hd0, 8'hff);
      rd(3'h1, 8'hc1, 8'hff);
    end
    wr(3'h3, 8'h02);
    wr(3'h3, 8'h00);
    repeat (3) @(posedge mclk_in);
    rd(3'h1, 8'he0, 8'hff);
    rd(3'h1, 8'hc1, 8'hff);
    wr(3'h3, 8'h40);
    wr(3'h2, 8'h50);
    // hysteresis between restore 8 and halt 16
    for (int i = 0; i < 5; i++)
    begin
      rx_fill_in <= fl[i][6:0];
      repeat (4) @(posedge mclk_in);
      @(negedge mclk_in);
      chk("rts", {7'h00, i == 2 || i == 3}, {7'h00, rts_n_out});
    end
    wr(3'h2, 8'h90);
    for (int j = 0; j < 2; j++)
    begin
      want <= {3'h7, j == 0};
      repeat (4) @(posedge mclk_in);
      @(negedge mclk_in);
      chk("halt", {7'h00, j == 0}, {7'h00, tx_halt_out});
    end
    stop_test;
  end
endmodule
